// File: mwatch_defs.vh
// register offsets, field positions and reset values of the memory watch enable block
`ifndef MWATCH_DEFS_VH
`define MWATCH_DEFS_VH
`define EVENT_OFS 12'h100
`define IRQ_ENABLE_OFS 12'h300
`define IRQ_SET_OFS 12'h304
`define IRQ_CLEAR_OFS 12'h308
`define NMI_ENABLE_OFS 12'h320
`define NMI_SET_OFS 12'h324
`define NMI_CLEAR_OFS 12'h328
`define EVT_STATUS_OFS 12'h340
`define EVT_MASK_OFS 12'h344
`define ENABLE_RESET 32'h00000000
`define USED_BITS 32'h0f0000ff
`define AREA_LO 0
`define AREA_HI 7
`define PERIPH_LO 24
`define PERIPH_HI 27
`endif

// File: enable_bank.v
// one enable set with direct, set-alias and clear-alias write paths
`timescale 1ns/10ps
module enable_bank (
    input wire core_clk, // clock
    input wire reset, // async reset, active high
    input wire writeDirect, // write to the direct register
    input wire writeSet, // write to the set alias
    input wire writeClear, // write to the clear alias
    input wire [31:0] writeData, // bus write data
    input wire [31:0] usedMask, // implemented bit positions
    output reg [31:0] enables // current enable state
);
    // unused positions forced to zero so they read back as zero
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            enables <= 32'h00000000;
        end else if (writeDirect) begin
            enables <= writeData & usedMask;
        end else if (writeSet) begin
            enables <= (enables | writeData) & usedMask; // zeros leave bits alone
        end else if (writeClear) begin
            enables <= enables & ~writeData & usedMask; // zeros leave bits alone
        end
    end
endmodule

// File: memory_watch_irq_nmi_enables.v
// interrupt and nmi enable logic of the memory watch unit, avalon-mm slave
// Notes on behaviour
// R1 - read/write nmi enable register, one bit per event, resets to zero
// R2 - set alias: writing 1 enables nmi routing for that event
// R3 - reading set or clear alias returns current enable state
// R4 - bits 0..7 are write then read events of areas 0 to 3
// R5 - bits 24..27 are write then read of peripheral areas; others read zero
// R6 - clear alias of nmi enables with the same layout
// R7 - writing 1 to a clear alias bit disables that enable
// R8 - event flags record region hits and source the irq and nmi requests
// R9 - zeros in set/clear writes change nothing; nmi while flag and enable set
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/10ps
`include "mwatch_defs.vh"
module memory_watch_irq_nmi_enables (
    input wire core_clk, // 25 MHz clock
    input wire reset, // async reset, active high
    input wire [11:0] address, // byte address
    input wire read, // avalon read
    input wire write, // avalon write
    input wire [3:0] byteenable, // byte lanes of a write
    input wire [31:0] writedata, // write data
    output reg [31:0] readdata, // read data
    output reg waitrequest, // high until the access is answered
    input wire [3:0] areaWriteHit, // write hits, areas 0..3, one-cycle pulses
    input wire [3:0] areaReadHit, // read hits, areas 0..3
    input wire [1:0] periphWriteHit, // write hits, peripheral areas 0..1
    input wire [1:0] periphReadHit, // read hits, peripheral areas 0..1
    output reg irqRequest, // maskable request, level
    output reg nmiRequest, // non-maskable request, level
    output reg statusIrq // level, sticky status set masked by evtMask
);
    wire [31:0] usedMask = `USED_BITS;
    wire [31:0] irqEnables;
    wire [31:0] nmiEnables;
    reg [31:0] eventFlags;
    reg [31:0] evtStatus;
    reg [31:0] evtMask;
    reg [31:0] hitVector;
    reg [31:0] evtClear;
    reg [31:0] next_readdata;
    reg [31:0] maskedData;
    reg busy;
    integer i;

    // bus accesses are taken with one wait cycle; answered the edge after
    wire access = (read | write) & ~busy;
    wire wrTake = write & busy;
    wire rdTake = read & busy;

    // byte lanes applied; disabled lanes are written as zero, so a direct write clears their bits
    always @* begin
        for (i = 0; i < 4; i = i + 1) begin
            maskedData[i*8 +: 8] = byteenable[i] ? writedata[i*8 +: 8] : 8'h00;
        end
    end

    // hit inputs assembled into the shared event layout
    always @* begin
        hitVector = 32'h00000000;
        for (i = 0; i < 4; i = i + 1) begin
            hitVector[2*i] = areaWriteHit[i]; // [R4]
            hitVector[2*i+1] = areaReadHit[i]; // [R4]
        end
        for (i = 0; i < 2; i = i + 1) begin
            hitVector[`PERIPH_LO+2*i] = periphWriteHit[i]; // [R5]
            hitVector[`PERIPH_LO+2*i+1] = periphReadHit[i]; // [R5]
        end
    end

    // event flag clear: writing 0 to an event word clears its flag
    always @* begin
        evtClear = 32'h00000000;
        for (i = 0; i < 4; i = i + 1) begin
            if (wrTake && address == `EVENT_OFS + 12'h008*i[11:0] && writedata[0] == 1'b0) begin
                evtClear[2*i] = 1'b1;
            end
            if (wrTake && address == `EVENT_OFS + 12'h008*i[11:0] + 12'h004 && writedata[0] == 1'b0) begin
                evtClear[2*i+1] = 1'b1;
            end
        end
        for (i = 0; i < 2; i = i + 1) begin
            if (wrTake && address == 12'h160 + 12'h008*i[11:0] && writedata[0] == 1'b0) begin
                evtClear[`PERIPH_LO+2*i] = 1'b1;
            end
            if (wrTake && address == 12'h164 + 12'h008*i[11:0] && writedata[0] == 1'b0) begin
                evtClear[`PERIPH_LO+2*i+1] = 1'b1;
            end
        end
    end

    // event flags: a hit in the clearing cycle wins over the clear
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            eventFlags <= 32'h00000000;
        end else begin
            eventFlags <= ((eventFlags & ~evtClear) | hitVector) & usedMask; // [R8]
        end
    end

    // irq enable set with its direct, set and clear addresses
    enable_bank irqBank (
        .core_clk(core_clk),
        .reset(reset),
        .writeDirect(wrTake && address == `IRQ_ENABLE_OFS),
        .writeSet(wrTake && address == `IRQ_SET_OFS),
        .writeClear(wrTake && address == `IRQ_CLEAR_OFS), // [R7]
        .writeData(maskedData),
        .usedMask(usedMask),
        .enables(irqEnables)
    );

    // nmi routing enables, same layout and access style
    enable_bank nmiBank (
        .core_clk(core_clk),
        .reset(reset),
        .writeDirect(wrTake && address == `NMI_ENABLE_OFS), // [R1]
        .writeSet(wrTake && address == `NMI_SET_OFS), // [R2] [R9]
        .writeClear(wrTake && address == `NMI_CLEAR_OFS), // [R6] [R7] [R9]
        .writeData(maskedData),
        .usedMask(usedMask),
        .enables(nmiEnables)
    );

    // sticky status of hits; read of status clears, a new hit wins
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            evtStatus <= 32'h00000000;
            evtMask <= 32'h00000000;
        end else begin
            if (rdTake && address == `EVT_STATUS_OFS) begin
                evtStatus <= hitVector;
            end else begin
                evtStatus <= evtStatus | hitVector;
            end
            if (wrTake && address == `EVT_MASK_OFS) begin
                evtMask <= maskedData & usedMask;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always @* begin
        next_readdata = 32'h00000000;
        case (address)
            `IRQ_ENABLE_OFS, `IRQ_SET_OFS, `IRQ_CLEAR_OFS: next_readdata = irqEnables;
            `NMI_ENABLE_OFS, `NMI_SET_OFS, `NMI_CLEAR_OFS: next_readdata = nmiEnables; // [R3]
            `EVT_STATUS_OFS: next_readdata = evtStatus;
            `EVT_MASK_OFS: next_readdata = evtMask;
            default: begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (address == `EVENT_OFS + 12'h008*i[11:0]) begin
                        next_readdata = {31'h00000000, eventFlags[2*i]};
                    end
                    if (address == `EVENT_OFS + 12'h008*i[11:0] + 12'h004) begin
                        next_readdata = {31'h00000000, eventFlags[2*i+1]};
                    end
                end
                for (i = 0; i < 2; i = i + 1) begin
                    if (address == 12'h160 + 12'h008*i[11:0]) begin
                        next_readdata = {31'h00000000, eventFlags[`PERIPH_LO+2*i]};
                    end
                    if (address == 12'h164 + 12'h008*i[11:0]) begin
                        next_readdata = {31'h00000000, eventFlags[`PERIPH_LO+2*i+1]};
                    end
                end
            end
        endcase
    end

    // bus handshake: waitrequest idles high, drops the edge after the request, rises one cycle later
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            busy <= 1'b0;
            waitrequest <= 1'b1;
            readdata <= 32'h00000000;
        end else begin
            busy <= access;
            waitrequest <= ~access;
            if (access && read) begin
                readdata <= next_readdata;
            end
        end
    end

    // registered request outputs; one cycle behind flag and enable
    always @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irqRequest <= 1'b0;
            nmiRequest <= 1'b0;
            statusIrq <= 1'b0;
        end else begin
            irqRequest <= |(eventFlags & irqEnables); // [R8]
            nmiRequest <= |(eventFlags & nmiEnables); // [R9]
            statusIrq <= |(evtStatus & evtMask);
        end
    end
endmodule

// File: memory_watch_irq_nmi_enables_checker.sv
// assertion checker for the memory watch enable block
`timescale 1ns/10ps
`include "mwatch_defs.vh"
module mw_enables_checker (
    input wire core_clk, // clock
    input wire reset, // async reset
    input wire [11:0] address, // byte address
    input wire read, // read request
    input wire write, // write request
    input wire [3:0] byteenable, // lanes
    input wire [31:0] writedata, // write data
    input wire [31:0] readdata, // read data
    input wire waitrequest, // answer strobe
    input wire [3:0] areaWriteHit, // area write hits
    input wire [3:0] areaReadHit, // area read hits
    input wire [1:0] periphWriteHit, // periph write hits
    input wire [1:0] periphReadHit, // periph read hits
    input wire irqRequest, // maskable request
    input wire nmiRequest, // nmi request
    input wire statusIrq // status level
);
    // any hit, and any of the six enable words
    wire anyHit = |{areaWriteHit, areaReadHit, periphWriteHit, periphReadHit};
    wire enReg = (address[11:4] == 8'h30 || address[11:4] == 8'h32) && address[3:2] != 2'h3;
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence s_req; (read || write) && waitrequest; endsequence
    sequence s_ans; !waitrequest ##1 waitrequest; endsequence
    property p_ans; s_req |=> s_ans; endproperty
    property p_only; !waitrequest |-> $past(read || write); endproperty
    property p_hold; !read |=> $stable(readdata); endproperty
    property p_unused; read && !waitrequest && enReg |-> (readdata & ~`USED_BITS) == 32'h0;
    endproperty
    property p_nmiRise; $rose(nmiRequest) |-> $past(anyHit, 2) || $past(write) || $past(write, 2);
    endproperty
    property p_nmiFall; $fell(nmiRequest) |-> $past(write) || $past(write, 2); endproperty
    property p_irqRise; $rose(irqRequest) |-> $past(anyHit, 2) || $past(write) || $past(write, 2);
    endproperty
    // a read of status or a mask write is the only way down
    property p_stFall; $fell(statusIrq) |-> $past(read || write) || $past(read || write, 2);
    endproperty
    a_ans: assert property (p_ans) else $error("access not answered in one cycle");
    a_only: assert property (p_only) else $error("answer without request");
    a_hold: assert property (p_hold) else $error("read data moved without read");
    a_unused: assert property (p_unused) else $error("unused enable bit set");
    a_nmiRise: assert property (p_nmiRise) else $error("nmi rose without cause");
    a_nmiFall: assert property (p_nmiFall) else $error("nmi fell without write");
    a_irqRise: assert property (p_irqRise) else $error("irq rose without cause");
    a_stFall: assert property (p_stFall) else $error("status fell without access");
endmodule
bind memory_watch_irq_nmi_enables mw_enables_checker chk (.core_clk(core_clk), .reset(reset),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .areaWriteHit(areaWriteHit), .areaReadHit(areaReadHit), .periphWriteHit(periphWriteHit),
    .periphReadHit(periphReadHit), .irqRequest(irqRequest), .nmiRequest(nmiRequest),
    .statusIrq(statusIrq));

// File: memory_watch_irq_nmi_enables_tb.sv
// self-checking bench for the memory watch enable block
`timescale 1ns/10ps
`include "mwatch_defs.vh"
module memory_watch_irq_nmi_enables_tb;
    logic core_clk = 0, reset = 1, read = 0, write = 0;
    logic [11:0] address = 0, hitv = 0, ev;
    logic [3:0] byteenable = 4'hf;
    logic [31:0] writedata = 0, rdata, m = 0, seed = 32'h02b39639, d;
    logic [11:0] offs[4] = '{12'h320, 12'h324, 12'h328, 12'h300};
    wire [31:0] readdata;
    wire waitrequest, irqRequest, nmiRequest, statusIrq;
    int error_cnt = 0, check_count = 0, op, b;
    memory_watch_irq_nmi_enables dut (.core_clk(core_clk), .reset(reset), .address(address),
        .read(read), .write(write), .byteenable(byteenable), .writedata(writedata),
        .readdata(readdata), .waitrequest(waitrequest),
        .areaWriteHit({hitv[6], hitv[4], hitv[2], hitv[0]}),
        .areaReadHit({hitv[7], hitv[5], hitv[3], hitv[1]}),
        .periphWriteHit({hitv[10], hitv[8]}), .periphReadHit({hitv[11], hitv[9]}),
        .irqRequest(irqRequest), .nmiRequest(nmiRequest), .statusIrq(statusIrq));
    // 40 ns clock
    initial forever #20 core_clk = ~core_clk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // expected enables after a direct, set or clear write
    function automatic logic [31:0] nxt(int o, logic [31:0] c, logic [31:0] v);
        if (o == 0) return v & `USED_BITS;
        if (o == 1) return c | (v & `USED_BITS);
        return c & ~(v & `USED_BITS);
    endfunction
    // one avalon access, held until waitrequest is seen low
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] v);
        read <= !w;
        write <= w;
        address <= a;
        writedata <= v;
        @(posedge core_clk);
        while (waitrequest !== 1'b0) @(posedge core_clk);
        rdata = readdata;
        read <= 0;
        write <= 0;
        @(posedge core_clk);
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            error_cnt++;
        end
    endtask
    // one-cycle hit pulse, then let flag and request settle
    task automatic pulse(input int j);
        hitv <= 12'h1 << j;
        @(posedge core_clk);
        hitv <= 0;
        repeat (3) @(posedge core_clk);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // watchdog, far beyond the expected run
    initial begin
        repeat (5000) @(posedge core_clk);
        error_cnt++;
        end_sim;
    end
    initial begin
        repeat (3) @(posedge core_clk);
        reset <= 0;
        foreach (offs[i]) begin
            acc(0, offs[i], 0);
            chk("reset value", 0, rdata);
        end
        $display("reset value test done");
        for (int i = 0; i < 30; i++) begin
            seed = xs(seed);
            d = seed;
            seed = xs(seed);
            op = seed % 3;
            acc(1, offs[op], d);
            m = nxt(op, m, d);
            acc(0, offs[seed[9:8] % 3], 0);
            chk("nmi enables", m, rdata);
        end
        $display("random alias test done");
        acc(1, 12'h320, 32'hffffffff);
        acc(0, 12'h324, 0);
        chk("used bits", `USED_BITS, rdata);
        byteenable <= 4'h1;
        acc(1, 12'h320, 32'hffffffff);
        byteenable <= 4'hf;
        acc(0, 12'h328, 0);
        chk("byte lanes", 32'h000000ff, rdata);
        acc(1, 12'h328, 32'hffffffff);
        acc(0, 12'h7fc, 0);
        chk("unmapped", 0, rdata);
        for (int j = 0; j < 12; j++) begin
            b = j < 8 ? j : j + 16;
            ev = j < 8 ? 12'h100 + 4 * j : 12'h160 + 4 * (j - 8);
            pulse(j);
            chk("nmi disabled", 0, nmiRequest);
            acc(1, 12'h324, 32'h1 << b);
            @(posedge core_clk);
            chk("nmi enabled", 1, nmiRequest);
            acc(1, 12'h328, 32'h1 << b);
            @(posedge core_clk);
            chk("nmi cleared", 0, nmiRequest);
            acc(1, ev, 0);
        end
        $display("event routing test done");
        acc(1, 12'h304, 32'h1);
        acc(0, 12'h308, 0);
        chk("irq enables", 32'h1, rdata);
        acc(1, 12'h344, 32'h1);
        pulse(0);
        chk("irq", 1, irqRequest);
        chk("status level", 1, statusIrq);
        acc(0, 12'h340, 0);
        chk("status bit", 1, rdata & 32'h1);
        @(posedge core_clk);
        chk("status cleared", 0, statusIrq);
        acc(1, 12'h344, 0);
        pulse(1);
        chk("status masked", 0, statusIrq);
        $display("interrupt test done");
        end_sim;
    end
endmodule
